// File: hdl/pclc_pkg.sv
// package of constants and types for the pulse count led current control
`default_nettype none
package pclc_pkg;
  localparam int unsigned clk_mhz         = 100;
  // latch and off hold times, microseconds
  localparam int unsigned latch_hold_us   = 500;
  localparam int unsigned off_hold_us     = 500;
  localparam int unsigned latch_hold_cyc  = latch_hold_us * clk_mhz;
  localparam int unsigned off_hold_cyc    = off_hold_us * clk_mhz;
  // soft start and auto-disable test window, microseconds
  localparam int unsigned start_us        = 100;
  localparam int unsigned start_cyc       = start_us * clk_mhz;
  localparam int unsigned test_us         = 10;
  localparam int unsigned test_cyc        = test_us * clk_mhz;
  localparam int unsigned timer_w         = 17;
  localparam logic [4:0]  code_max        = 5'h10;
  localparam logic [4:0]  code_reset      = 5'h00;
  localparam logic [3:0]  level_reset     = 4'h0;
  // sink current per code, units of 10 uA
  localparam logic [10:0] cur_table [16] = '{
    11'h7d0, 11'h6a4, 11'h578, 11'h4b0, 11'h3e8, 11'h35c, 11'h2bc, 11'h258,
    11'h1f4, 11'h1a4, 11'h154, 11'h118, 11'h064, 11'h032, 11'h00a, 11'h005};
  localparam logic [10:0] test_current    = 11'h00a;
  localparam logic [10:0] max_current     = 11'h7d0;

  typedef enum logic [2:0] {
    pclc_off   = 3'b000,
    pclc_start = 3'b001,
    pclc_test  = 3'b010,
    pclc_run   = 3'b011
  } pclc_state_t;

  typedef enum logic [1:0] {
    pclc_pump_1x  = 2'b00,
    pclc_pump_15x = 2'b01,
    pclc_pump_2x  = 2'b10
  } pclc_pump_t;
endpackage : pclc_pkg
`default_nettype wire

// File: hdl/pclc_if.sv
// interface carrying the decoded level from the edge counter
`default_nettype none
interface pclc_if;
  logic       latch;
  logic [3:0] level;
  logic       off;
  modport counter (output latch, output level, output off);
  modport ctrl    (input latch, input level, input off);
endinterface : pclc_if
`default_nettype wire

// File: hdl/pclc_counter.sv
// edge counter with latch and off hold timers on the enable line
`default_nettype none
module pclc_counter #(
  parameter int unsigned latch_cyc = pclc_pkg::latch_hold_cyc,
  parameter int unsigned off_cyc   = pclc_pkg::off_hold_cyc
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  input  wire logic  en_set,
  pclc_if.counter    lnk
);
  logic                        en_q;
  logic [4:0]                  count;
  logic [pclc_pkg::timer_w-1:0] hi_t;
  logic [pclc_pkg::timer_w-1:0] lo_t;
  logic                        is_off;
  logic                        rise;

  assign rise = en_set && !en_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_set;
    end
  end

  // high and low hold timers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_t <= '0;
      lo_t <= '0;
    end else begin
      hi_t <= (en_set && en_q) ? ((hi_t == latch_cyc[pclc_pkg::timer_w-1:0])
              ? hi_t : hi_t + 1'b1) : '0;
      lo_t <= (!en_set && !en_q) ? ((lo_t == off_cyc[pclc_pkg::timer_w-1:0])
              ? lo_t : lo_t + 1'b1) : '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      is_off <= 1'b1;
    end else if (lo_t == off_cyc[pclc_pkg::timer_w-1:0] - 1'b1) begin
      is_off <= 1'b1;
    end else if (rise) begin
      is_off <= 1'b0;
    end
  end

  // count, latch and clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count     <= pclc_pkg::code_reset;
      lnk.latch <= 1'b0;
      lnk.level <= pclc_pkg::level_reset;
    end else begin
      lnk.latch <= 1'b0;
      if (is_off && !en_set && !rise && lo_t != '0) begin
        count <= pclc_pkg::code_reset;
      end else if (rise) begin
        count <= (count == pclc_pkg::code_max) ? count : count + 1'b1;
      end else if (hi_t == latch_cyc[pclc_pkg::timer_w-1:0] - 1'b1
                   && count != '0) begin
        lnk.latch <= 1'b1;
        lnk.level <= 4'(count - 1'b1);
        count     <= pclc_pkg::code_reset;
      end
    end
  end

  assign lnk.off = is_off;
endmodule : pclc_counter
`default_nettype wire

// File: hdl/pclc_top.sv
// led current sink control: sequencing, auto-disable, pump mode, thermal
// Operation
// - rising edges on the enable line are counted into sixteen levels
// - codes 1 to 16 map from 20.0 mA down to 0.05 mA
// - first twelve codes step about 1.5 dB, last four low scale
// - edges counted correctly from 15 kHz up to above 1 MHz
// - after the latch hold time level applies and count clears
// - low past off hold time enters shutdown, sinks and pump off
// - count held at zero while in shutdown
// - after start-up a 100 uA test current flows in each sink
// - sinks failing the test threshold are disabled and kept off
// - pump starts only when a good sink signals near dropout, then stays on in run until over-temperature, else 1x
// - pump starts at 1.5x, steps to 2x on another dropout
// - one level drives all four sinks, at most 20 mA each
// - over-temperature shuts down the charge pump
`default_nettype none
module pclc_top #(
  parameter int unsigned latch_cyc = pclc_pkg::latch_hold_cyc,
  parameter int unsigned off_cyc   = pclc_pkg::off_hold_cyc,
  parameter int unsigned start_cyc = pclc_pkg::start_cyc,
  parameter int unsigned test_cyc  = pclc_pkg::test_cyc
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        en_set,
  input  wire logic [3:0]  sink_low,
  input  wire logic [3:0]  near_dropout,
  input  wire logic        over_temp,
  output logic [3:0]       sink_enable,
  output logic [10:0]      sink_current,
  output logic             test_active,
  output logic             pump_enable,
  output pclc_pkg::pclc_pump_t pump_mode,
  output logic             active
);
  pclc_if lnk ();
  pclc_pkg::pclc_state_t state;
  pclc_pkg::pclc_state_t next_state;
  logic [pclc_pkg::timer_w-1:0] tmr;
  logic [3:0]  good;
  logic [3:0]  level;
  logic        have_level;
  logic [3:0]  drop_q;
  logic        drop_rise;
  logic        drop_any;

  pclc_counter #(.latch_cyc(latch_cyc), .off_cyc(off_cyc)) u_cnt (
    .clk    (clk),
    .rstn   (rstn),
    .en_set (en_set),
    .lnk    (lnk)
  );

  function automatic logic [10:0] level_current(input logic [3:0] lv);
    logic [10:0] c;
    c = pclc_pkg::cur_table[lv];
    level_current = (c > pclc_pkg::max_current) ? pclc_pkg::max_current : c;
  endfunction : level_current

  // state decodes shared by the outputs, auto-disable and pump
  function automatic logic in_off(input pclc_pkg::pclc_state_t st);
    in_off = (st == pclc_pkg::pclc_off);
  endfunction : in_off

  function automatic logic in_test(input pclc_pkg::pclc_state_t st);
    in_test = (st == pclc_pkg::pclc_test);
  endfunction : in_test

  function automatic logic in_run(input pclc_pkg::pclc_state_t st);
    in_run = (st == pclc_pkg::pclc_run);
  endfunction : in_run

  // phase timer has reached the length of the current phase
  function automatic logic phase_done(
    input logic [pclc_pkg::timer_w-1:0] t,
    input int unsigned                  lim
  );
    phase_done = (t == lim[pclc_pkg::timer_w-1:0]);
  endfunction : phase_done

  always_comb begin
    next_state = state;
    case (state)
      pclc_pkg::pclc_off: begin
        if (lnk.latch) begin
          next_state = pclc_pkg::pclc_start;
        end
      end
      pclc_pkg::pclc_start: begin
        if (phase_done(tmr, start_cyc)) begin
          next_state = pclc_pkg::pclc_test;
        end
      end
      pclc_pkg::pclc_test: begin
        if (phase_done(tmr, test_cyc)) begin
          next_state = pclc_pkg::pclc_run;
        end
      end
      pclc_pkg::pclc_run: begin
        next_state = pclc_pkg::pclc_run;
      end
      default: begin
        next_state = pclc_pkg::pclc_off;
      end
    endcase
    if (lnk.off) begin
      next_state = pclc_pkg::pclc_off;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= pclc_pkg::pclc_off;
    end else begin
      state <= next_state;
    end
  end

  // phase timer restarts on every change of state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr <= '0;
    end else if (next_state != state) begin
      tmr <= '0;
    end else begin
      tmr <= tmr + 1'b1;
    end
  end

  // latched level kept until shutdown
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level      <= pclc_pkg::level_reset;
      have_level <= 1'b0;
    end else if (lnk.off) begin
      have_level <= 1'b0;
    end else if (lnk.latch) begin
      level      <= lnk.level;
      have_level <= 1'b1;
    end
  end

  // auto-disable sampling at end of test window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      good <= 4'h0;
    end else if (in_off(state)) begin
      good <= 4'h0;
    end else if (in_test(state) && phase_done(tmr, test_cyc)) begin
      good <= sink_low;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active <= 1'b0;
    end else begin
      active <= !in_off(state);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      test_active <= 1'b0;
    end else begin
      test_active <= in_test(state);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sink_enable <= 4'h0;
    end else if (in_test(state)) begin
      sink_enable <= 4'hf;
    end else if (in_run(state) && have_level) begin
      sink_enable <= good;
    end else begin
      sink_enable <= 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sink_current <= 11'h000;
    end else if (in_test(state)) begin
      sink_current <= pclc_pkg::test_current;
    end else if (in_run(state) && have_level) begin
      sink_current <= level_current(level);
    end else begin
      sink_current <= 11'h000;
    end
  end

  // pump mode selection; a dropout already present at run entry counts
  assign drop_any  = |(near_dropout & good);
  assign drop_rise = |(near_dropout & good & ~drop_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drop_q <= 4'h0;
    end else begin
      drop_q <= near_dropout & good;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pump_enable <= 1'b0;
    end else if (!in_run(state) || over_temp) begin
      pump_enable <= 1'b0;
    end else if (drop_any) begin
      pump_enable <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pump_mode <= pclc_pkg::pclc_pump_1x;
    end else if (!in_run(state) || over_temp) begin
      pump_mode <= pclc_pkg::pclc_pump_1x;
    end else if (!pump_enable && drop_any) begin
      pump_mode <= pclc_pkg::pclc_pump_15x;
    end else if (pump_enable && drop_rise) begin
      pump_mode <= pclc_pkg::pclc_pump_2x;
    end
  end
endmodule : pclc_top
`default_nettype wire

// File: tb/pclc_host.sv
// host model driving the enable/set line with edge bursts
`default_nettype none
module pclc_host #(
  parameter int unsigned latch_cyc = 20
) (
  input  wire logic clk,
  output logic      en_set
);
  timeunit 1ns;
  timeprecision 1ps;
  initial en_set = 1'b0;
  // n edges, w cycles per phase, then hold high to latch if asked
  task automatic send(input int n, input int w, input bit hold);
    repeat (n) begin
      @(posedge clk) #1 en_set = 1'b0;
      repeat (w) @(posedge clk);
      #1 en_set = 1'b1;
      repeat (w) @(posedge clk);
    end
    if (hold) repeat (latch_cyc + 3) @(posedge clk);
  endtask : send
  task automatic low(input int c);
    @(posedge clk) #1 en_set = 1'b0;
    repeat (c) @(posedge clk);
  endtask : low
endmodule : pclc_host
`default_nettype wire

// File: tb/pclc_top_sva.sv
// checker of the led current control top ports
`default_nettype none
module pclc_top_sva #(
  parameter int unsigned off_cyc = 20
) (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic                 en_set,
  input wire logic [3:0]           sink_low,
  input wire logic [3:0]           near_dropout,
  input wire logic                 over_temp,
  input wire logic [3:0]           sink_enable,
  input wire logic [10:0]          sink_current,
  input wire logic                 test_active,
  input wire logic                 pump_enable,
  input wire pclc_pkg::pclc_pump_t pump_mode,
  input wire logic                 active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [15:0] low_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) low_cnt <= 16'h0000;
    else if (en_set) low_cnt <= 16'h0000;
    else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h0001;
  end
  off_sinks_a: assert property (
    !active |-> sink_enable == 4'h0) else $error("sinks on in shutdown");
  off_pump_a: assert property (
    !active |-> !pump_enable) else $error("pump on in shutdown");
  off_timeout_a: assert property (
    low_cnt == 16'(off_cyc + 3) |-> !active) else $error("no shutdown");
  hot_pump_a: assert property (
    over_temp |=> !pump_enable) else $error("pump on while hot");
  cur_limit_a: assert property (
    sink_current <= 11'h7d0) else $error("sink current above limit");
  test_cur_a: assert property (
    test_active |-> sink_current == 11'h00a) else $error("bad test current");
  test_sinks_a: assert property (
    test_active |-> sink_enable == 4'hf) else $error("sinks off in test");
  pump_start_a: assert property (
    $rose(pump_enable) |-> pump_mode == pclc_pkg::pclc_pump_15x)
    else $error("pump not started at 1.5x");
  pump_step_a: assert property (
    $changed(pump_mode) && pump_mode == pclc_pkg::pclc_pump_2x
    |-> $past(pump_mode) == pclc_pkg::pclc_pump_15x) else $error("bad step");
  pump_cause_a: assert property (
    $rose(pump_enable) |-> $past(|near_dropout)) else $error("pump no cause");
  pump_idle_a: assert property (
    !pump_enable |-> pump_mode == pclc_pkg::pclc_pump_1x)
    else $error("pump mode set while idle");
endmodule : pclc_top_sva
bind pclc_top pclc_top_sva #(.off_cyc(off_cyc)) chk (.clk(clk), .rstn(rstn),
  .en_set(en_set), .sink_low(sink_low), .near_dropout(near_dropout),
  .over_temp(over_temp), .sink_enable(sink_enable),
  .sink_current(sink_current), .test_active(test_active),
  .pump_enable(pump_enable), .pump_mode(pump_mode), .active(active));
`default_nettype wire

// File: tb/pclc_top_tb.sv
// testbench of the led current control top
`default_nettype none
module pclc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned lc = 20;
  localparam int unsigned oc = 20;
  localparam logic [10:0] cur [16] = '{11'h7d0, 11'h6a4, 11'h578, 11'h4b0,
    11'h3e8, 11'h35c, 11'h2bc, 11'h258, 11'h1f4, 11'h1a4, 11'h154, 11'h118,
    11'h064, 11'h032, 11'h00a, 11'h005};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic en_set;
  logic [3:0] sink_low = 4'hb;
  logic [3:0] near_dropout = 4'h0;
  logic over_temp = 1'b0;
  logic [3:0] sink_enable;
  logic [10:0] sink_current;
  logic test_active, pump_enable, active;
  pclc_pkg::pclc_pump_t pump_mode;
  int errors = 0;
  int checks = 0;
  always #5 clk = ~clk;
  pclc_host #(.latch_cyc(lc)) host (.clk(clk), .en_set(en_set));
  pclc_top #(.latch_cyc(lc), .off_cyc(oc), .start_cyc(10), .test_cyc(5)) dut (
    .clk(clk), .rstn(rstn), .en_set(en_set), .sink_low(sink_low),
    .near_dropout(near_dropout), .over_temp(over_temp),
    .sink_enable(sink_enable), .sink_current(sink_current),
    .test_active(test_active), .pump_enable(pump_enable),
    .pump_mode(pump_mode), .active(active));
  task automatic chk(input string n, input logic [10:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic t_enable;
    host.send(3, 4, 1);
    for (int i = 0; i < 40 && test_active !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("test window", {10'h000, test_active}, 11'h001);
    chk("test current", sink_current, 11'h00a);
    chk("test sinks", {7'h00, sink_enable}, 11'h00f);
    repeat (15) @(posedge clk);
    #1;
    chk("level", sink_current, cur[2]);
    chk("good sinks", {7'h00, sink_enable}, 11'h00b);
    @(posedge clk) #1 sink_low = 4'hf;
    repeat (3) @(posedge clk);
    chk("kept off", {7'h00, sink_enable}, 11'h00b);
  endtask : t_enable
  task automatic t_levels;
    for (int n = 1; n <= 16; n++) begin
      host.send(n, (n % 2) ? 15 : 4, 1);
      repeat (4) @(posedge clk);
      #1;
      chk("code", sink_current, cur[n-1]);
    end
    host.send(20, 4, 1);
    repeat (4) @(posedge clk);
    #1;
    chk("saturated", sink_current, cur[15]);
  endtask : t_levels
  task automatic t_pump;
    chk("pump idle", {10'h000, pump_enable}, 11'h000);
    @(posedge clk) #1 near_dropout = 4'h1;
    repeat (5) @(posedge clk);
    chk("pump on", {10'h000, pump_enable}, 11'h001);
    chk("mode 1.5x", {9'h000, pump_mode}, 11'h001);
    @(posedge clk) #1 near_dropout = 4'h0;
    repeat (3) @(posedge clk);
    #1 near_dropout = 4'h1;
    repeat (5) @(posedge clk);
    chk("mode 2x", {9'h000, pump_mode}, 11'h002);
    #1 over_temp = 1'b1;
    repeat (3) @(posedge clk);
    chk("hot pump", {10'h000, pump_enable}, 11'h000);
    #1 over_temp = 1'b0;
    near_dropout = 4'h0;
  endtask : t_pump
  task automatic t_off;
    host.send(2, 4, 0);
    host.low(oc + 5);
    #1;
    chk("shutdown", {10'h000, active}, 11'h000);
    chk("sinks off", {7'h00, sink_enable}, 11'h000);
    chk("pump off", {10'h000, pump_enable}, 11'h000);
    host.send(1, 4, 1);
    repeat (30) @(posedge clk);
    #1;
    chk("count cleared", sink_current, cur[0]);
    chk("retested sinks", {7'h00, sink_enable}, 11'h00f);
  endtask : t_off
  initial begin
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    t_enable();
    t_levels();
    t_pump();
    t_off();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule : pclc_top_tb
`default_nettype wire
